// ==== include/capp_params.svh ====
// constants for the current adc post-processing block
// Function
// - config bit 7 set connects the ground switch pin to analog ground.
// - ground switch enable with mode bit 6 selects the 20 kohm path.
// - accumulator field 00 stops accumulation and clears the total.
// - mode 01 adds positive, subtracts negative, total clamped at zero.
// - mode 10 adds positive, subtracts magnitude, total may go negative.
// - accumulator is 32 bits and wraps on overflow.
// - comparator field 00 disables comparator and its interrupt; a flag already set still drives cur_irq until a status read.
// - comparator mode 01 flags every result with magnitude at or above threshold.
// - mode 10 flags after limit hits; a low result zeroes the count.
// - mode 11 counts hits; a low result decrements count, floor zero.
// - bit 2 enables overrange flag after 125 us continuous gross overrange.
// - bit 0 enables result count mode; interrupt only when count equals limit.
// - in count mode only the latest voltage/temperature result is held.
// - result count resets to zero on reaching the limit and restarts.
// - 8-bit threshold count increments on hits; flag when equals limit.
// - unipolar compares 16 threshold bits; twos complement compares 15.
// - writes to channel control or mode register clear the result count.
`ifndef CAPP_PARAMS_SVH
`define CAPP_PARAMS_SVH
`define CAPP_OFS_CFG 12'h000
`define CAPP_OFS_MODE 12'h004
`define CAPP_OFS_CHCON 12'h008
`define CAPP_OFS_STATUS 12'h00c
`define CAPP_OFS_THRESH 12'h010
`define CAPP_OFS_TCL 12'h014
`define CAPP_OFS_THV 12'h018
`define CAPP_OFS_RCL 12'h01c
`define CAPP_OFS_RCV 12'h020
`define CAPP_OFS_ACC 12'h024
`define CAPP_OFS_VTDAT 12'h028
`define CAPP_CFG_RESET 8'h00
`define CAPP_TCL_RESET 8'h01
`define CAPP_RCL_RESET 16'h0001
`define CAPP_BIT_GSW 7
`define CAPP_BIT_OVR 2
`define CAPP_BIT_RCEN 0
`define CAPP_MODE_BIT_RES 6
`define CAPP_CLK_MHZ 125
`define CAPP_OVR_TIME_US 125
`define CAPP_OVR_CYCLES ((`CAPP_OVR_TIME_US * `CAPP_CLK_MHZ) + 1)
`define CAPP_ST_READY 0
`define CAPP_ST_VTREADY 1
`define CAPP_ST_CMP 3
`define CAPP_ST_OVR 4
`endif

// ==== include/capp_pkg.sv ====
// types for the current adc post-processing block
package capp_pkg;
  typedef enum logic [1:0] {
    CAPP_ACC_OFF = 2'b00,
    CAPP_ACC_CLAMP = 2'b01,
    CAPP_ACC_SIGNED = 2'b10,
    CAPP_ACC_UNDEF = 2'b11
  } capp_acc_mode_t;
  typedef enum logic [1:0] {
    CAPP_CMP_OFF = 2'b00,
    CAPP_CMP_SINGLE = 2'b01,
    CAPP_CMP_RESET = 2'b10,
    CAPP_CMP_DECR = 2'b11
  } capp_cmp_mode_t;
  // one conversion result, from the current or the voltage/temperature channel
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } capp_result_t;
  typedef struct packed {
    logic gnd_switch;
    capp_acc_mode_t acc_mode;
    capp_cmp_mode_t cmp_mode;
    logic ovr_en;
    logic rsvd;
    logic rc_en;
  } capp_cfg_t;
endpackage : capp_pkg

// ==== rtl/capp_core.sv ====
// current adc post-processing: config, accumulator, comparator, counters
`timescale 1ns/1ns
`include "capp_params.svh"
module capp_core #(
  parameter int OVR_CYCLES = `CAPP_OVR_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire capp_pkg::capp_result_t cur_result,
  input wire capp_pkg::capp_result_t vt_result,
  input wire logic twos_comp,
  input wire logic overrange_raw,
  output logic ground_switch_pin,
  output logic ground_switch_resistive,
  output logic cur_irq
);
  import capp_pkg::*;

  logic [7:0] cfg_reg;
  logic [7:0] mode_reg;
  logic [15:0] thresh_reg;
  logic [7:0] tcl_reg;
  logic [7:0] thv_reg;
  logic [15:0] rcl_reg;
  logic [15:0] rcv_reg;
  logic [31:0] acc_reg;
  logic [15:0] vtdat_reg;
  logic ready_reg;
  logic vtready_reg;
  logic cmp_reg;
  logic ovr_reg;
  logic [2:0] ovr_sync_reg;
  logic ovr_level_reg;
  logic [$clog2(OVR_CYCLES+1)-1:0] ovr_cnt_reg;
  capp_cfg_t cfg;
  capp_acc_mode_t acc_mode;
  capp_cmp_mode_t cmp_mode;

  // absolute value of a result, as 16 bits
  // the most negative code maps to 0x8000, above any 15-bit threshold
  function automatic logic [15:0] mag_of(input logic [15:0] v,
                                         input logic tc);
    if (tc && v[15]) begin
      mag_of = 16'(~v + 16'h0001);
    end else begin
      mag_of = v;
    end
  endfunction : mag_of

  assign cfg = capp_cfg_t'(cfg_reg);
  assign acc_mode = cfg.acc_mode;
  assign cmp_mode = cfg.cmp_mode;

  // apb decode; zero wait states, unmapped reads zero and error
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_cfg = paddr == `CAPP_OFS_CFG;
  wire hit_mode = paddr == `CAPP_OFS_MODE;
  wire hit_chcon = paddr == `CAPP_OFS_CHCON;
  wire hit_status = paddr == `CAPP_OFS_STATUS;
  wire hit_thresh = paddr == `CAPP_OFS_THRESH;
  wire hit_tcl = paddr == `CAPP_OFS_TCL;
  wire hit_thv = paddr == `CAPP_OFS_THV;
  wire hit_rcl = paddr == `CAPP_OFS_RCL;
  wire hit_rcv = paddr == `CAPP_OFS_RCV;
  wire hit_acc = paddr == `CAPP_OFS_ACC;
  wire hit_vtdat = paddr == `CAPP_OFS_VTDAT;
  wire mapped = hit_cfg | hit_mode | hit_chcon | hit_status | hit_thresh |
                hit_tcl | hit_thv | hit_rcl | hit_rcv | hit_acc | hit_vtdat;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // result event and comparator decisions
  wire conv = cur_result.valid;
  wire [15:0] cur_mag = mag_of(cur_result.data, twos_comp);
  // twos complement data ignores the top threshold bit
  wire [15:0] th_eff = twos_comp ? {1'b0, thresh_reg[14:0]} : thresh_reg;
  wire at_or_above = cur_mag >= th_eff;
  wire cur_neg = twos_comp && cur_result.data[15];
  wire [31:0] mag32 = {16'h0000, cur_mag};
  wire [31:0] acc_sub = acc_reg - mag32;
  wire acc_under = acc_reg < mag32;
  wire rc_hit = cfg.rc_en && (16'(rcv_reg + 16'h0001) == rcl_reg);
  // reconfiguring the converter restarts the result count
  wire rc_clear = wr && (hit_chcon || hit_mode);
  wire [7:0] thv_inc = 8'(thv_reg + 8'h01);
  wire thv_limit = thv_inc == tcl_reg;
  wire ovr_agree = ovr_sync_reg[2] == ovr_sync_reg[1];
  wire ovr_level = ovr_level_reg;
  // status reads clear the sticky flags; a set in that cycle still wins
  wire clr_flags = rd && hit_status;

  // pins from config
  // the resistive path only matters while the switch is closed
  assign ground_switch_pin = cfg.gnd_switch;
  assign ground_switch_resistive =
    cfg.gnd_switch && mode_reg[`CAPP_MODE_BIT_RES];

  // read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      if (hit_cfg) prdata = {24'h0, cfg_reg};
      if (hit_mode) prdata = {24'h0, mode_reg};
      if (hit_status) prdata = {27'h0, ovr_reg, cmp_reg, 1'b0,
                                vtready_reg, ready_reg};
      if (hit_thresh) prdata = {16'h0, thresh_reg};
      if (hit_tcl) prdata = {24'h0, tcl_reg};
      if (hit_thv) prdata = {24'h0, thv_reg};
      if (hit_rcl) prdata = {16'h0, rcl_reg};
      if (hit_rcv) prdata = {16'h0, rcv_reg};
      if (hit_acc) prdata = acc_reg;
      if (hit_vtdat) prdata = {16'h0, vtdat_reg};
    end
  end

  // configuration byte; bit 1 is kept as written, software leaves it zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `CAPP_CFG_RESET;
    end else if (wr && hit_cfg) begin
      cfg_reg <= pwdata[7:0];
    end
  end

  // local stand-in for the converter mode byte; only bit 6 is used here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 8'h00;
    end else if (wr && hit_mode) begin
      mode_reg <= pwdata[7:0];
    end
  end

  // current threshold, compared against result magnitudes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_reg <= 16'h0000;
    end else if (wr && hit_thresh) begin
      thresh_reg <= pwdata[15:0];
    end
  end

  // threshold count limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcl_reg <= `CAPP_TCL_RESET;
    end else if (wr && hit_tcl) begin
      tcl_reg <= pwdata[7:0];
    end
  end

  // result count limit; zero only matches once the count wraps, on the 65536th result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcl_reg <= `CAPP_RCL_RESET;
    end else if (wr && hit_rcl) begin
      rcl_reg <= pwdata[15:0];
    end
  end

  // 32-bit accumulator, wraps on the positive side
  // mode 11 is undefined; the total simply holds there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 32'h0000_0000;
    end else if (acc_mode == CAPP_ACC_OFF) begin
      acc_reg <= 32'h0000_0000;
    end else if (conv && !cur_neg && acc_mode != CAPP_ACC_UNDEF) begin
      acc_reg <= 32'(acc_reg + mag32);
    end else if (conv && acc_mode == CAPP_ACC_CLAMP) begin
      acc_reg <= acc_under ? 32'h0000_0000 : acc_sub;
    end else if (conv && acc_mode == CAPP_ACC_SIGNED) begin
      acc_reg <= acc_sub;
    end
  end

  // threshold count and comparator flag; set wins over read clear
  // a count that reaches the limit restarts from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thv_reg <= 8'h00;
      cmp_reg <= 1'b0;
    end else if (cmp_mode == CAPP_CMP_OFF) begin
      thv_reg <= 8'h00;
      cmp_reg <= cmp_reg && !clr_flags;
    end else if (conv && at_or_above) begin
      if (cmp_mode == CAPP_CMP_SINGLE) begin
        cmp_reg <= 1'b1;
      end else begin
        thv_reg <= thv_limit ? 8'h00 : thv_inc;
        cmp_reg <= thv_limit || (cmp_reg && !clr_flags);
      end
    end else begin
      if (conv && cmp_mode == CAPP_CMP_RESET) begin
        thv_reg <= 8'h00;
      end else if (conv && cmp_mode == CAPP_CMP_DECR && thv_reg != 8'h00) begin
        thv_reg <= 8'(thv_reg - 8'h01);
      end
      cmp_reg <= cmp_reg && !clr_flags;
    end
  end

  // result counter; reconfiguring or leaving count mode restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcv_reg <= 16'h0000;
    end else if (rc_clear || !cfg.rc_en || (conv && rc_hit)) begin
      rcv_reg <= 16'h0000;
    end else if (conv) begin
      rcv_reg <= 16'(rcv_reg + 16'h0001);
    end
  end

  // current ready flag; without count mode every conversion sets it,
  // with count mode only the conversion that meets the limit does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
    end else if (conv && (!cfg.rc_en || rc_hit)) begin
      ready_reg <= 1'b1;
    end else if (clr_flags) begin
      ready_reg <= 1'b0;
    end
  end

  // voltage/temperature data: keep only the latest result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vtdat_reg <= 16'h0000;
    end else if (vt_result.valid) begin
      vtdat_reg <= vt_result.data;
    end
  end

  // voltage/temperature ready; in count mode it waits for the counter,
  // so intermediate results are overwritten without raising a flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vtready_reg <= 1'b0;
    end else if (vt_result.valid && !cfg.rc_en) begin
      vtready_reg <= 1'b1;
    end else if (conv && rc_hit) begin
      vtready_reg <= 1'b1;
    end else if (clr_flags) begin
      vtready_reg <= 1'b0;
    end
  end

  // pin synchroniser: the coarse comparator is not on this clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_sync_reg <= 3'b000;
    end else begin
      ovr_sync_reg <= {ovr_sync_reg[1:0], overrange_raw};
    end
  end

  // the level only moves once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_level_reg <= 1'b0;
    end else if (ovr_agree) begin
      ovr_level_reg <= ovr_sync_reg[2];
    end
  end

  // run length of the overrange level; saturates so it cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_cnt_reg <= '0;
    end else if (!cfg.ovr_en || !ovr_level) begin
      ovr_cnt_reg <= '0;
    end else if (ovr_cnt_reg != $bits(ovr_cnt_reg)'(OVR_CYCLES)) begin
      ovr_cnt_reg <= $bits(ovr_cnt_reg)'(ovr_cnt_reg + 1'b1);
    end
  end

  // sticky overrange flag once the run is long enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_reg <= 1'b0;
    end else if (cfg.ovr_en && ovr_level &&
                 ovr_cnt_reg == $bits(ovr_cnt_reg)'(OVR_CYCLES - 1)) begin
      ovr_reg <= 1'b1;
    end else if (clr_flags) begin
      ovr_reg <= 1'b0;
    end
  end

  // interrupt level: ready, comparator or overrange flag; the voltage/temperature ready bit is not included
  // a level, not a pulse: it drops when a status read clears the flags
  assign cur_irq = ready_reg || cmp_reg || ovr_reg;
endmodule : capp_core

// ==== tb/capp_core_sva.sv ====
// assertion checker bound to the post-processing core
`timescale 1ns/1ns
module capp_sva #(
  parameter int OVR_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire capp_pkg::capp_result_t cur_result,
  input wire capp_pkg::capp_result_t vt_result,
  input wire logic twos_comp,
  input wire logic overrange_raw,
  input wire logic ground_switch_pin,
  input wire logic ground_switch_resistive,
  input wire logic cur_irq
);
  import capp_pkg::*;
  logic [7:0] cfg_reg;
  logic mode6_reg;
  wire wr_take = psel && penable && pwrite;
  // shadow of config and mode writes, taken at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= 8'h00;
      mode6_reg <= 1'b0;
    end else if (wr_take) begin
      if (paddr == 12'h000) cfg_reg <= pwdata[7:0];
      if (paddr == 12'h004) mode6_reg <= pwdata[6];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  a_pin_cfg: assert property (ground_switch_pin == cfg_reg[7])
    else $error("ground switch pin differs from config");
  a_res_path: assert property (
    ground_switch_resistive == (cfg_reg[7] && mode6_reg))
    else $error("resistive path select wrong");
  a_ready_high: assert property (s_acc |-> pready)
    else $error("access without ready");
  a_err_unmap: assert property (s_acc ##0 (paddr > 12'h028 ||
    paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (s_acc ##0 (paddr <= 12'h028 &&
    paddr[1:0] == 2'b00) |-> !pslverr)
    else $error("mapped access refused");
  a_rdata_idle: assert property (!(psel && penable) |-> prdata == 32'h0)
    else $error("read data outside access");
  a_conv_ready: assert property (
    cur_result.valid && !cfg_reg[0] |=> cur_irq)
    else $error("conversion did not raise ready");
  a_rst_quiet: assert property ($rose(presetn) |-> !ground_switch_pin && !cur_irq)
    else $error("outputs active after reset");
endmodule : capp_sva

bind capp_core capp_sva #(.OVR_CYCLES(OVR_CYCLES)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cur_result(cur_result),
  .vt_result(vt_result), .twos_comp(twos_comp),
  .overrange_raw(overrange_raw), .ground_switch_pin(ground_switch_pin),
  .ground_switch_resistive(ground_switch_resistive), .cur_irq(cur_irq)
);

// ==== tb/tb.sv ====
// self-checking bench for the post-processing core
`timescale 1ns/1ns
module tb;
  import capp_pkg::*;
  localparam int OVR = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err_q, hit, fl;
  logic twos_comp = 1'b0;
  logic overrange_raw = 1'b0;
  logic ground_switch_pin, ground_switch_resistive, cur_irq;
  capp_result_t cur_result = '0;
  capp_result_t vt_result = '0;
  int errors = 0;
  int samples_checked = 0;
  int acc_m, thv_m, d;
  // comparator corners: bit i of tt is twos mode, of te the expected flag
  logic [5:0] tt = 6'h07;
  logic [5:0] te = 6'h0d;
  logic [15:0] th[6] = '{16'h8064, 16'h8064, 16'h8064, 16'h8000,
    16'h8000, 16'h0000};
  logic [15:0] tdat[6] = '{16'hff9c, 16'h0063, 16'h8000, 16'h8000,
    16'h7fff, 16'hffff};
  always #4 pclk = ~pclk;
  capp_core #(.OVR_CYCLES(OVR)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cur_result(cur_result),
    .vt_result(vt_result), .twos_comp(twos_comp),
    .overrange_raw(overrange_raw), .ground_switch_pin(ground_switch_pin),
    .ground_switch_resistive(ground_switch_resistive), .cur_irq(cur_irq));
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; an idle cycle follows so strobes never double up
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      end_sim();
    end
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  // one current conversion event, valid for a single cycle
  task automatic conv(input logic [15:0] v);
    cur_result <= '{1'b1, v};
    @(posedge pclk);
    cur_result <= '{1'b0, v};
    @(posedge pclk);
  endtask : conv
  function automatic int acc_f(input int a, input int v, input logic cl);
    acc_f = a + v;
    if (cl && acc_f < 0) acc_f = 0;
  endfunction : acc_f
  initial begin
    d = $urandom(13);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(12'h000, 32'h0);
    rchk(12'h014, 32'h1);
    rchk(12'h01c, 32'h1);
    rchk(12'h0fc, 32'h0);
    chk(32'(err_q), 32'h1);
    bus(1'b1, 12'h004, 32'h40);
    bus(1'b1, 12'h000, 32'h80);
    chk(32'(ground_switch_pin), 32'h1);
    chk(32'(ground_switch_resistive), 32'h1);
    bus(1'b1, 12'h000, 32'h00);
    chk(32'(ground_switch_pin), 32'h0);
    // clamped then signed accumulation, first sample drives below zero
    twos_comp <= 1'b1;
    for (int m = 1; m <= 2; m++) begin
      bus(1'b1, 12'h000, 32'(m) << 5);
      acc_m = 0;
      for (int i = 0; i < 40; i++) begin
        d = (i == 0) ? -300 : int'($signed(16'($urandom)));
        conv(16'(d));
        acc_m = acc_f(acc_m, d, m == 1);
      end
      rchk(12'h024, acc_m);
      bus(1'b1, 12'h000, 32'h0);
      conv(16'h0010);
      conv(16'h0010);
      rchk(12'h024, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      twos_comp <= tt[i];
      bus(1'b1, 12'h010, 32'(th[i]));
      bus(1'b1, 12'h000, 32'(i < 5) << 3);
      bus(1'b0, 12'h00c, 32'h0);
      conv(tdat[i]);
      bus(1'b0, 12'h00c, 32'h0);
      chk(32'(rd[3]), 32'(te[i]));
    end
    // count modes: a reset or a decrement on a miss
    twos_comp <= 1'b1;
    bus(1'b1, 12'h010, 32'h64);
    bus(1'b1, 12'h014, 32'h3);
    for (int m = 2; m <= 3; m++) begin
      bus(1'b1, 12'h000, 32'h0);
      rchk(12'h018, 32'h0);
      bus(1'b1, 12'h000, 32'(m) << 3);
      bus(1'b0, 12'h00c, 32'h0);
      thv_m = 0;
      for (int i = 0; i < 10; i++) begin
        hit = (i != 2) && ($urandom % 4 != 0);
        conv(hit ? 16'hff38 : 16'h0005);
        if (hit) thv_m++;
        else thv_m = (m == 2 || thv_m == 0) ? 0 : thv_m - 1;
        fl = (thv_m == 3);
        if (fl) thv_m = 0;
        bus(1'b0, 12'h00c, 32'h0);
        chk(32'(rd[3]), 32'(fl));
        rchk(12'h018, thv_m);
      end
    end
    bus(1'b1, 12'h01c, 32'h3);
    bus(1'b1, 12'h000, 32'h01);
    bus(1'b0, 12'h00c, 32'h0);
    for (int i = 1; i <= 4; i++) begin
      conv(16'h0001);
      chk(32'(cur_irq), 32'(i == 3));
      rchk(12'h020, 32'(i % 3));
      bus(1'b0, 12'h00c, 32'h0);
    end
    bus(1'b1, 12'h008, 32'h0);
    rchk(12'h020, 32'h0);
    vt_result <= '{1'b1, 16'h1234};
    @(posedge pclk);
    vt_result <= '{1'b1, 16'h4321};
    @(posedge pclk);
    vt_result <= '{1'b0, 16'h0000};
    @(posedge pclk);
    rchk(12'h028, 32'h4321);
    bus(1'b0, 12'h00c, 32'h0);
    chk(32'(rd[1]), 32'h0);
    // overrange: a short burst is ignored, a long one sets the flag
    bus(1'b1, 12'h000, 32'h04);
    bus(1'b0, 12'h00c, 32'h0);
    overrange_raw <= 1'b1;
    repeat (OVR - 4) @(posedge pclk);
    overrange_raw <= 1'b0;
    repeat (4) @(posedge pclk);
    bus(1'b0, 12'h00c, 32'h0);
    chk(32'(rd[4]), 32'h0);
    overrange_raw <= 1'b1;
    repeat (OVR + 8) @(posedge pclk);
    bus(1'b0, 12'h00c, 32'h0);
    chk(32'(rd[4]), 32'h1);
    end_sim();
  end
endmodule : tb
